// File: rtl/fast_integer_divider.sv
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - every division instruction completes in one cycle.
// - host instruction set and pipeline stay untouched.
// - six extra division source/destination registers.
// - sign step saves sign flags, makes magnitudes.
// - conditional subtract runs several iterations per cycle.
// - sign step restores quotient and remainder signs.
// - truncated, floored and Euclidean conventions supported.
// - signed/unsigned 16, 32, 64-bit operand mixes.
// - each step separate, interruptible between steps.
// - negint takes numerator sign, test takes XOR.
// - most negative sets overflow latch, clears remainder.
// - sign step touches only test, negint, overflow.
module fast_integer_divider (
  input wire logic clk,
  input wire logic reset_n,
  input wire fast_integer_divider_pkg::instr_t instr,
  input wire fast_integer_divider_pkg::hostWr_t hostWr,
  output fast_integer_divider_pkg::divRegs_t regsOut,
  output fast_integer_divider_pkg::flags_t flagsOut,
  output logic irq,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import fast_integer_divider_pkg::*;

  state_t st_r;
  state_t st_nxt;
  logic ovfClr;

  // Word-aligned address inside the map; shared by read and write decode.
  function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_IRQ_MASK);
  endfunction : addrMapped

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] val,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction : mergeStrb

  function automatic logic [31:0] readWord(input state_t s, input logic [ADDR_W-1:0] a);
    logic [31:0] res;
    res = 32'h0;
    if (a < ADDR_FLAGS) begin
      res = s.regs[a[4:2]];
    end else if (a == ADDR_FLAGS) begin
      res[FLAG_TEST_BIT] = s.flags.test;
      res[FLAG_NEGINT_BIT] = s.flags.negInt;
      res[FLAG_OVF_BIT] = s.flags.ovfLatch;
    end else if (a == ADDR_IRQ_STAT) begin
      res[IRQ_W-1:0] = s.irqStat;
    end else if (a == ADDR_IRQ_MASK) begin
      res[IRQ_W-1:0] = s.irqMask;
    end
    // An unmapped or misaligned read returns zero rather than a neighbouring register.
    return addrMapped(a) ? res : 32'h0;
  endfunction : readWord

  // One restoring division step: shift the numerator into the partial remainder and
  // subtract the divisor when it fits; the quotient bit enters at the numerator bottom.
  function automatic logic [127:0] subcStep(input logic [63:0] num, input logic [63:0] rem,
                                            input logic [63:0] den, input logic wide);
    logic [64:0] sh;
    logic [63:0] n;
    sh = {rem, wide ? num[63] : num[31]};
    n = {num[62:0], 1'b0};
    if (sh >= {1'b0, den}) begin
      sh = sh - {1'b0, den};
      n[0] = 1'b1;
    end
    return {n, sh[63:0]};
  endfunction : subcStep

  // Turn unsigned quotient and remainder into the signed result of the chosen convention.
  function automatic logic [127:0] signFix(input logic [63:0] q, input logic [63:0] r,
                                           input logic [63:0] d, input divType_t t, input flags_t f);
    logic denNeg;
    logic adjust;
    logic [63:0] qo;
    logic [63:0] ro;
    denNeg = f.test ^ f.negInt;
    adjust = (r != 64'h0) && (((t == DIV_FLOOR) && f.test) || ((t == DIV_EUCLID) && f.negInt));
    qo = adjust ? q + 64'h1 : q;
    ro = adjust ? d - r : r;
    qo = f.test ? -qo : qo;
    case (t)
      DIV_TRUNC: ro = f.negInt ? -ro : ro;
      DIV_FLOOR: ro = denNeg ? -ro : ro;
      default: ro = ro;
    endcase
    return {qo, ro};
  endfunction : signFix

  // Next-state logic: bus slave, host register port, then the division step, which wins.
  always_comb begin
    logic numWide;
    logic denWide;
    logic isAbs;
    logic isSigned;
    logic evOvf;
    logic evDz;
    logic doWrite;
    logic [63:0] num;
    logic [63:0] den;
    logic [63:0] rem;
    logic [127:0] pair;
    logic [IRQ_W-1:0] statClr;
    // Operand views. 16-bit operands arrive sign- or zero-extended in the 32-bit form.
    numWide = instr.op inside {OP_ABS_I64_32, OP_ABS_U64_32, OP_ABS_I64_64, OP_ABS_U64_64,
                               OP_SUBC_64, OP_SIGN_64_32, OP_SIGN_64_64};
    denWide = instr.op inside {OP_ABS_I64_64, OP_ABS_U64_64, OP_SUBC_64, OP_SIGN_64_64};
    isAbs = instr.op inside {OP_ABS_I32, OP_ABS_U32, OP_ABS_I64_32, OP_ABS_U64_32, OP_ABS_I64_64,
                             OP_ABS_U64_64};
    isSigned = instr.op inside {OP_ABS_I32, OP_ABS_I64_32, OP_ABS_I64_64};
    num = numWide ? {st_r.regs[IDX_NUM], st_r.regs[IDX_NUM_LO]} : {32'h0, st_r.regs[IDX_NUM]};
    den = denWide ? {st_r.regs[IDX_DEN], st_r.regs[IDX_DEN_LO]} : {32'h0, st_r.regs[IDX_DEN]};
    rem = denWide ? {st_r.regs[IDX_REM], st_r.regs[IDX_REM_LO]} : {32'h0, st_r.regs[IDX_REM]};
    evOvf = 1'b0;
    evDz = 1'b0;
    doWrite = 1'b0;
    pair = '0;
    statClr = '0;
    ovfClr = 1'b0;
    st_nxt = st_r;

    // Write channel: address and data may arrive in either order.
    case (st_r.wrState)
      WR_IDLE: begin
        if (awvalid && wvalid) begin
          st_nxt.awAddr = awaddr;
          st_nxt.wData = wdata;
          st_nxt.wStrb = wstrb;
          st_nxt.wrState = WR_RESP;
          doWrite = 1'b1;
        end else if (awvalid) begin
          st_nxt.awAddr = awaddr;
          st_nxt.wrState = WR_ADDR;
        end else if (wvalid) begin
          st_nxt.wData = wdata;
          st_nxt.wStrb = wstrb;
          st_nxt.wrState = WR_DATA;
        end
      end
      WR_ADDR: begin
        if (wvalid) begin
          st_nxt.wData = wdata;
          st_nxt.wStrb = wstrb;
          st_nxt.wrState = WR_RESP;
          doWrite = 1'b1;
        end
      end
      WR_DATA: begin
        if (awvalid) begin
          st_nxt.awAddr = awaddr;
          st_nxt.wrState = WR_RESP;
          doWrite = 1'b1;
        end
      end
      default: begin
        if (bready) begin
          st_nxt.wrState = WR_IDLE;
        end
      end
    endcase

    if (doWrite) begin
      st_nxt.bresp = addrMapped(st_nxt.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (addrMapped(st_nxt.awAddr) && (st_nxt.awAddr < ADDR_FLAGS)) begin
        st_nxt.regs[st_nxt.awAddr[4:2]] = mergeStrb(st_r.regs[st_nxt.awAddr[4:2]], st_nxt.wData,
                                                    st_nxt.wStrb);
      end else if (st_nxt.awAddr == ADDR_FLAGS) begin
        ovfClr = st_nxt.wStrb[0] && st_nxt.wData[FLAG_OVF_BIT];
      end else if (st_nxt.awAddr == ADDR_IRQ_STAT) begin
        statClr = st_nxt.wStrb[0] ? st_nxt.wData[IRQ_W-1:0] : '0;
      end else if (st_nxt.awAddr == ADDR_IRQ_MASK) begin
        st_nxt.irqMask = st_nxt.wStrb[0] ? st_nxt.wData[IRQ_W-1:0] : st_r.irqMask;
      end
    end
    if (ovfClr) begin
      st_nxt.flags.ovfLatch = 1'b0;
    end

    // Read channel: data is presented one cycle after the address is taken.
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end else if (st_r.arready && arvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = readWord(st_r, araddr);
      st_nxt.rresp = addrMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // The host pipeline loads operands through its own port; the base CPU is left as is.
    if (hostWr.valid && (hostWr.idx < 3'(NUM_DIV_REGS))) begin
      st_nxt.regs[hostWr.idx] = hostWr.data;
    end

    // Each instruction is a complete single-cycle step, so an interrupt may land between steps.
    if (instr.valid && (instr.op != OP_NOP)) begin
      if (isAbs) begin
        st_nxt.flags.negInt = st_r.regs[IDX_NUM][31];
        st_nxt.flags.test = st_r.regs[IDX_NUM][31] ^ (isSigned && st_r.regs[IDX_DEN][31]);
        evOvf = numWide ? (num == MIN_I64) : (num[31:0] == MIN_I32);
        if (isSigned) begin
          evOvf = evOvf || (denWide ? (den == MIN_I64) : (den[31:0] == MIN_I32));
          if (st_r.regs[IDX_DEN][31]) begin
            den = denWide ? -den : {32'h0, -den[31:0]};
          end
        end
        if (st_r.regs[IDX_NUM][31]) begin
          num = numWide ? -num : {32'h0, -num[31:0]};
        end
        rem = 64'h0;
        evDz = (den == 64'h0);
        // Only these three flags move; zero and float flags of the host stay put.
        if (evOvf) begin
          st_nxt.flags.ovfLatch = 1'b1;
        end
      end else if (instr.op inside {OP_SUBC_32, OP_SUBC_64}) begin
        for (int i = 0; i < SUBC_ITER_32; i++) begin
          if (!numWide || (i < SUBC_ITER_64)) begin
            pair = subcStep(num, rem, den, numWide);
            num = pair[127:64];
            rem = pair[63:0];
          end
        end
      end else begin
        pair = signFix(num, rem, den, instr.divType, st_r.flags);
        num = pair[127:64];
        rem = pair[63:0];
      end
      st_nxt.regs[IDX_NUM] = numWide ? num[63:32] : num[31:0];
      st_nxt.regs[IDX_REM] = denWide ? rem[63:32] : rem[31:0];
      st_nxt.regs[IDX_DEN] = denWide ? den[63:32] : den[31:0];
      if (numWide) begin
        st_nxt.regs[IDX_NUM_LO] = num[31:0];
      end
      if (denWide) begin
        st_nxt.regs[IDX_REM_LO] = rem[31:0];
        st_nxt.regs[IDX_DEN_LO] = den[31:0];
      end
    end

    // Sticky events: a new event in the clearing cycle survives the clear.
    st_nxt.irqStat = st_r.irqStat & ~statClr;
    st_nxt.irqStat[IRQ_OVF_BIT] = st_nxt.irqStat[IRQ_OVF_BIT] | evOvf;
    st_nxt.irqStat[IRQ_DIVZERO_BIT] = st_nxt.irqStat[IRQ_DIVZERO_BIT] | evDz;
    st_nxt.irq = |(st_nxt.irqStat & st_nxt.irqMask);

    // Ready flags are registered so every bus output leaves a flip-flop.
    st_nxt.awready = (st_nxt.wrState == WR_IDLE) || (st_nxt.wrState == WR_DATA);
    st_nxt.wready = (st_nxt.wrState == WR_IDLE) || (st_nxt.wrState == WR_ADDR);
    st_nxt.bvalid = (st_nxt.wrState == WR_RESP);
  end

  // Synchronous reset clears the division registers and the flags.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output is a field of the state register.
  assign regsOut = st_r.regs;
  assign flagsOut = st_r.flags;
  assign irq = st_r.irq;
  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;

  // Checks on the divider datapath and its flags.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_abs_clears_rem: assert property (
    instr.valid && instr.op == OP_ABS_I32 |=> regsOut[IDX_REM] == 32'h0)
    else $error("Sign step left remainder non-zero.");
  chk_negint_sign: assert property (
    instr.valid && instr.op == OP_ABS_I32 |=> flagsOut.negInt == $past(regsOut[IDX_NUM][31]))
    else $error("Negative flag does not follow numerator sign.");
  chk_test_xor: assert property (
    instr.valid && instr.op inside {OP_ABS_I32, OP_ABS_I64_32, OP_ABS_I64_64}
    |=> flagsOut.test == ($past(regsOut[IDX_NUM][31]) ^ $past(regsOut[IDX_DEN][31])))
    else $error("Test flag is not the sign XOR.");
  // The event is registered with the latch, so an enabled interrupt shows in the same cycle.
  chk_ovf_on_min: assert property (
    instr.valid && instr.op == OP_ABS_I32 && regsOut[IDX_NUM] == MIN_I32
    |=> flagsOut.ovfLatch && (irq || !st_r.irqMask[IRQ_OVF_BIT]))
    else $error("Most negative numerator did not set overflow.");
  chk_abs_magnitude: assert property (
    instr.valid && instr.op == OP_ABS_I32 |=> !regsOut[IDX_NUM][31] || regsOut[IDX_NUM] == MIN_I32)
    else $error("Numerator is not a magnitude after sign step.");
  chk_subc_bound: assert property (
    instr.valid && instr.op == OP_SUBC_32 && !hostWr.valid
    && regsOut[IDX_DEN] != 32'h0 && regsOut[IDX_REM] < regsOut[IDX_DEN]
    |=> regsOut[IDX_REM] < regsOut[IDX_DEN])
    else $error("Partial remainder not below divisor.");
  chk_trunc_negate: assert property (
    instr.valid && instr.op == OP_SIGN_32 && instr.divType == DIV_TRUNC
    && flagsOut.test |=> regsOut[IDX_NUM] == 32'(-$past(regsOut[IDX_NUM])))
    else $error("Truncated quotient sign wrong.");
  chk_ovf_sticky: assert property (flagsOut.ovfLatch && !ovfClr |=> flagsOut.ovfLatch)
    else $error("Overflow latch dropped without a clear.");
  chk_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
    !reset_n |=> regsOut == '0 && flagsOut == '0)
    else $error("Reset did not clear divider state.");

  cov_full_sequence: cover property (instr.valid && instr.op == OP_ABS_I32 ##1 instr.op == OP_SUBC_32 [*8]
    ##1 instr.op == OP_SIGN_32);
  cov_bus_write: cover property (bvalid && bready);
  cov_irq_rise: cover property ($rose(irq));

endmodule : fast_integer_divider

// File: rtl/fast_integer_divider_pkg.sv
package fast_integer_divider_pkg;

  // Register file shape and word positions of the division registers.
  localparam int NUM_DIV_REGS = 6;
  localparam logic [2:0] IDX_NUM_LO = 3'h0;
  localparam logic [2:0] IDX_NUM = 3'h1;
  localparam logic [2:0] IDX_REM = 3'h2;
  localparam logic [2:0] IDX_DEN = 3'h3;
  localparam logic [2:0] IDX_REM_LO = 3'h4;
  localparam logic [2:0] IDX_DEN_LO = 3'h5;

  // Bus map, byte addresses.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_DIVREG0 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Field positions in the flag word and in the interrupt words.
  localparam int FLAG_TEST_BIT = 0;
  localparam int FLAG_NEGINT_BIT = 1;
  localparam int FLAG_OVF_BIT = 2;
  localparam int IRQ_W = 2;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_DIVZERO_BIT = 1;

  // Arithmetic constants.
  localparam int SUBC_ITER_32 = 4;
  localparam int SUBC_ITER_64 = 2;
  localparam logic [31:0] MIN_I32 = 32'h8000_0000;
  localparam logic [63:0] MIN_I64 = 64'h8000_0000_0000_0000;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ABS_I32 = 4'h1, OP_ABS_U32 = 4'h2, OP_ABS_I64_32 = 4'h3,
    OP_ABS_U64_32 = 4'h4, OP_ABS_I64_64 = 4'h5, OP_ABS_U64_64 = 4'h6, OP_SUBC_32 = 4'h7,
    OP_SUBC_64 = 4'h8, OP_SIGN_32 = 4'h9, OP_SIGN_64_32 = 4'hA, OP_SIGN_64_64 = 4'hB
  } divOp_t;

  typedef enum logic [1:0] {DIV_TRUNC = 2'h0, DIV_FLOOR = 2'h1, DIV_EUCLID = 2'h2} divType_t;

  typedef enum logic [1:0] {WR_IDLE = 2'h0, WR_ADDR = 2'h1, WR_DATA = 2'h2, WR_RESP = 2'h3} wrState_t;

  typedef struct packed {logic valid; divOp_t op; divType_t divType;} instr_t;
  typedef struct packed {logic valid; logic [2:0] idx; logic [31:0] data;} hostWr_t;
  typedef struct packed {logic ovfLatch; logic negInt; logic test;} flags_t;
  typedef logic [NUM_DIV_REGS-1:0][31:0] divRegs_t;

  typedef struct packed {
    divRegs_t regs; flags_t flags; logic [IRQ_W-1:0] irqStat; logic [IRQ_W-1:0] irqMask; logic irq;
    wrState_t wrState; logic [ADDR_W-1:0] awAddr; logic [31:0] wData; logic [3:0] wStrb;
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } state_t;

  localparam state_t STATE_RST = '{regs: '0, flags: '0, irqStat: '0, irqMask: '0, irq: 1'b0,
    wrState: WR_IDLE, awAddr: '0, wData: '0, wStrb: '0, awready: 1'b1, wready: 1'b1, bvalid: 1'b0,
    bresp: RESP_OKAY, arready: 1'b1, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY};

endpackage : fast_integer_divider_pkg

// File: sim/host_pipeline_model.sv
`timescale 1ns/1ns
// Stand-in for the host pipeline: it issues one division step per clock.
module host_pipeline_model (
  input wire logic clk,
  output fast_integer_divider_pkg::instr_t instr,
  output fast_integer_divider_pkg::hostWr_t hostWr
);
  import fast_integer_divider_pkg::*;

  // Quiet at time zero, so nothing is taken while reset is held.
  initial begin
    instr = '0;
    hostWr = '0;
  end

  // Register load; the value is visible after the next edge.
  task automatic load(input logic [2:0] idx, input logic [31:0] data);
    @(posedge clk);
    instr <= '0;
    hostWr <= '{valid: 1'b1, idx: idx, data: data};
  endtask : load

  // Each step is its own instruction, so an interrupt may fall between any two.
  task automatic issue(input divOp_t op, input divType_t t);
    @(posedge clk);
    hostWr <= '0;
    instr <= '{valid: 1'b1, op: op, divType: t};
  endtask : issue

  task automatic idle();
    @(posedge clk);
    instr <= '0;
    hostWr <= '0;
  endtask : idle

  // Loads, sign extraction, back-to-back subtracts, then sign assignment.
  task automatic divide(input logic [63:0] num, input logic [63:0] den, input divOp_t absOp,
                        input divType_t t, input logic wide, input logic absOnly);
    load(IDX_NUM, wide ? num[63:32] : num[31:0]);
    load(IDX_DEN, wide ? den[63:32] : den[31:0]);
    if (wide) begin
      load(IDX_NUM_LO, num[31:0]);
      load(IDX_DEN_LO, den[31:0]);
    end
    issue(absOp, t);
    if (!absOnly) begin
      for (int i = 0; i < (wide ? 64 / SUBC_ITER_64 : 32 / SUBC_ITER_32); i++) begin
        issue(wide ? OP_SUBC_64 : OP_SUBC_32, t);
      end
      issue(wide ? OP_SIGN_64_64 : OP_SIGN_32, t);
    end
    idle();
  endtask : divide
endmodule : host_pipeline_model

// File: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  import fast_integer_divider_pkg::*;
  typedef struct {logic [63:0] num; logic [63:0] den; divOp_t absOp; divType_t t; logic wide;
                  flags_t fl; logic [63:0] q; logic [63:0] r;} rowCase_t;
  logic clk, resetN, irq, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  instr_t instr;
  hostWr_t hostWr;
  divRegs_t regsOut;
  flags_t flagsOut;
  int nErrors = 0, checkCount = 0, cycles = 0;
  rowCase_t rows[10];

  fast_integer_divider i_fast_integer_divider (.clk(clk), .reset_n(resetN), .instr(instr), .hostWr(hostWr),
    .regsOut(regsOut), .flagsOut(flagsOut), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  host_pipeline_model i_host_pipeline_model (.clk(clk), .instr(instr), .hostWr(hostWr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The whole run needs about three hundred and fifty cycles; a hang ends here.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      $display("ERROR t=%0t timeout got=%h exp=%h", $time, cycles, 0);
      report_and_stop();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [63:0] pick(input logic [31:0] hi, input logic [31:0] lo, input logic wide);
    return wide ? {hi, lo} : {32'h0, hi};
  endfunction : pick

  // Expected value cut to the width the division step keeps.
  function automatic logic [63:0] trim(input logic [63:0] v, input logic wide);
    return wide ? v : {32'h0, v[31:0]};
  endfunction : trim

  // Bus write: both channels offered together, each released once taken.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone, wDone;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awDone = 1'b0;
    wDone = 1'b0;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && awready) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    logic w;
    logic [63:0] mag;
    {resetN, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    rows = '{'{64'h7, 64'h2, OP_ABS_I32, DIV_TRUNC, 1'b0, 3'h0, 64'h3, 64'h1},
             '{-64'h7, 64'h2, OP_ABS_I32, DIV_TRUNC, 1'b0, 3'h3, -64'h3, -64'h1},
             '{-64'h7, 64'h2, OP_ABS_I32, DIV_FLOOR, 1'b0, 3'h3, -64'h4, 64'h1},
             '{64'h7, -64'h2, OP_ABS_I32, DIV_FLOOR, 1'b0, 3'h1, -64'h4, -64'h1},
             '{-64'h7, -64'h2, OP_ABS_I32, DIV_EUCLID, 1'b0, 3'h2, 64'h4, 64'h1},
             '{64'h7, -64'h2, OP_ABS_I32, DIV_EUCLID, 1'b0, 3'h1, -64'h3, 64'h1},
             '{-64'h7, 64'h2, OP_ABS_U32, DIV_TRUNC, 1'b0, 3'h3, -64'h3, -64'h1},
             '{-64'h64, 64'h7, OP_ABS_I64_64, DIV_TRUNC, 1'b1, 3'h3, -64'hE, -64'h2},
             '{-64'h64, 64'h7, OP_ABS_I64_64, DIV_EUCLID, 1'b1, 3'h3, -64'hF, 64'h5},
             '{-64'h64, 64'h7, OP_ABS_U64_64, DIV_FLOOR, 1'b1, 3'h3, -64'hF, 64'h5}};
    repeat (20) @(posedge clk);
    resetN <= 1'b1;
    #1;
    for (int i = 0; i < NUM_DIV_REGS; i++) check({32'h0, regsOut[i]}, 64'h0);
    check({60'h0, flagsOut, irq}, 64'h0);
    // Each row: sign extraction alone first, then the whole division.
    foreach (rows[k]) begin
      w = rows[k].wide;
      mag = rows[k].num[63] ? -rows[k].num : rows[k].num;
      i_host_pipeline_model.divide(rows[k].num, rows[k].den, rows[k].absOp, rows[k].t, w, 1'b1);
      #1;
      check(pick(regsOut[IDX_NUM], regsOut[IDX_NUM_LO], w), trim(mag, w));
      check({32'h0, regsOut[IDX_REM]}, 64'h0);
      check({61'h0, flagsOut}, {61'h0, rows[k].fl});
      i_host_pipeline_model.divide(rows[k].num, rows[k].den, rows[k].absOp, rows[k].t, w, 1'b0);
      #1;
      check(pick(regsOut[IDX_NUM], regsOut[IDX_NUM_LO], w), trim(rows[k].q, w));
      check(pick(regsOut[IDX_REM], regsOut[IDX_REM_LO], w), trim(rows[k].r, w));
    end
    $display("Test done: division table");
    // Wide numerator over a narrow negative denominator: the test flag is the sign XOR.
    i_host_pipeline_model.divide(-64'h64, {-32'h7, 32'h0}, OP_ABS_I64_32, DIV_TRUNC, 1'b1, 1'b1);
    #1;
    check(pick(regsOut[IDX_NUM], regsOut[IDX_NUM_LO], 1'b1), 64'h64);
    check({32'h0, regsOut[IDX_DEN]}, 64'h7);
    check({61'h0, flagsOut}, 64'h2);
    $display("Test done: wide by narrow sign step");
    // Most negative numerator with a stale remainder, interrupt still masked.
    i_host_pipeline_model.load(IDX_REM, 32'h5);
    i_host_pipeline_model.divide(64'h8000_0000, 64'h1, OP_ABS_I32, DIV_TRUNC, 1'b0, 1'b1);
    #1;
    check({regsOut[IDX_NUM], regsOut[IDX_REM]}, {MIN_I32, 32'h0});
    check({60'h0, flagsOut, irq}, 64'hE);
    axiRead(ADDR_IRQ_STAT, rd, resp);
    check({30'h0, resp, rd}, 64'h1);
    axiWrite(ADDR_IRQ_MASK, 32'h1, resp);
    @(posedge clk);
    #1;
    check({63'h0, irq}, 64'h1);
    axiWrite(ADDR_IRQ_STAT, 32'h1, resp);
    @(posedge clk);
    #1;
    check({63'h0, irq}, 64'h0);
    axiWrite(ADDR_FLAGS, 32'h4, resp);
    axiRead(ADDR_FLAGS, rd, resp);
    check({30'h0, resp, rd}, 64'h3);
    $display("Test done: overflow and interrupt");
    // All six division registers over the bus, then unmapped places.
    for (int i = 0; i < NUM_DIV_REGS; i++) begin
      axiWrite(ADDR_DIVREG0 + 8'(4 * i), 32'hA5A5_0000 | 32'(i), resp);
      axiRead(ADDR_DIVREG0 + 8'(4 * i), rd, resp);
      check({30'h0, resp, rd}, {32'h0, 32'hA5A5_0000 | 32'(i)});
    end
    axiRead(8'h24, rd, resp);
    check({30'h0, resp, rd}, {30'h0, RESP_SLVERR, 32'h0});
    axiWrite(8'h02, 32'hFFFF_FFFF, resp);
    check({62'h0, resp}, {62'h0, RESP_SLVERR});
    $display("Test done: register bus");
    // Reset in mid-run clears the registers written above.
    @(posedge clk);
    resetN <= 1'b0;
    repeat (2) @(posedge clk);
    resetN <= 1'b1;
    #1;
    for (int i = 0; i < NUM_DIV_REGS; i++) check({32'h0, regsOut[i]}, 64'h0);
    check({61'h0, flagsOut}, 64'h0);
    $display("Test done: second reset");
    report_and_stop();
  end
endmodule : testbench
